// ### common/dgcp_pkg.sv
// package: register map, field positions and carrier types of the dma block
package dgcp_pkg;
  // ***********************************************************
  // sizes
  // ***********************************************************
  localparam int NCH = 4; // number of channels
  localparam int ADDR_W = 8; // axi address width
  localparam int DATA_W = 32; // axi data width
  localparam int BYTE_W = 8; // pattern byte width
  localparam int IDX_W = 4; // word index width
  localparam int IDX_LSB = 2; // word index lowest address bit
  // ***********************************************************
  // register word indexes (byte address = index * 4)
  // ***********************************************************
  localparam logic [IDX_W-1:0] IDX_GLOBAL = 4'h0; // dma_global_control
  localparam logic [IDX_W-1:0] IDX_MODE = 4'h1; // pattern mode enables
  localparam logic [IDX_W-1:0] IDX_HIT = 4'h2; // match hit flags, w1c
  localparam logic [IDX_W-1:0] IDX_MATCH0 = 4'h4; // channel_match_byte 0
  // ***********************************************************
  // field positions and reset values
  // ***********************************************************
  localparam int ON_BIT = 15; // module enable
  localparam int SUSPEND_BIT = 12; // transfer suspend
  localparam int BUSY_BIT = 11; // dma_active_flag
  localparam int LANE_CTRL = 1; // byte lane holding on and suspend
  localparam int LANE_MATCH = 0; // byte lane holding the pattern
  localparam logic RST_BIT = 1'h0; // reset value of control bits
  localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00; // reset pattern byte
  localparam logic [NCH-1:0] RST_CH = 4'h0; // reset channel bit vector
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000; // zero word
  // ***********************************************************
  // axi responses
  // ***********************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0; // access done
  localparam logic [1:0] RESP_SLVERR = 2'h2; // unmapped address
  // ***********************************************************
  // carrier types
  // ***********************************************************
  typedef struct packed {
    logic valid; // a byte is offered for transfer
    logic [BYTE_W-1:0] data; // the byte itself
  } dgcp_beat_t;
endpackage

// ### verilog/dgcp_match_unit.sv
// file: per-channel pattern compare that ends a transfer on a match
`timescale 1ns/1ps
module dgcp_match_unit (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic xfer, // a byte moves this cycle
  input wire logic [dgcp_pkg::BYTE_W-1:0] data, // the moving byte
  input wire logic [dgcp_pkg::BYTE_W-1:0] pattern, // byte to be matched
  input wire logic pattern_mode, // channel is in pattern terminate mode
  output logic done // one-cycle pulse: transfer ended on match
);
  // ***********************************************************
  // compare
  // ***********************************************************
  // the pattern is looked at only in pattern mode
  wire logic equal = (data == pattern);
  wire logic next_done = xfer & pattern_mode & equal;

  // registered terminate pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done <= dgcp_pkg::RST_BIT;
    end else if (ce) begin
      done <= next_done;
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  match_end_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && xfer && pattern_mode && data == pattern) |=> done)
    else $error("matched byte did not end the transfer");

  mode_ignore_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && !pattern_mode) |=> !done)
    else $error("terminate raised outside pattern mode");
endmodule

// ### verilog/dgcp_top.sv
// file: global control, busy status and channel match bytes of the dma block
// Operation
// - global enable bit 15 turns the whole dma module on; 0 keeps it off
// - suspend bit 12 holds off every transfer; 0 lets transfers run
// - busy bit 11 reads 1 whenever the module is active
// - busy bit reads 0 when disabled and nothing is transferring
// - control bits 31-16, 14-13 and 10-0 always read zero
// - match byte register bits 31-8 read zero
// - outside pattern terminate mode the match byte is ignored
`timescale 1ns/1ps
module dgcp_top (
  input wire logic aclk, // system clock, 40 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes state when low
  // axi4-lite write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [dgcp_pkg::ADDR_W-1:0] awaddr, // write address
  // axi4-lite write data
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  input wire logic [dgcp_pkg::DATA_W-1:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  // axi4-lite write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  output logic [1:0] bresp, // write response code
  // axi4-lite read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  input wire logic [dgcp_pkg::ADDR_W-1:0] araddr, // read address
  // axi4-lite read data
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic [dgcp_pkg::DATA_W-1:0] rdata, // read data
  output logic [1:0] rresp, // read response code
  // channel engines
  input wire dgcp_pkg::dgcp_beat_t [dgcp_pkg::NCH-1:0] ch_beat, // bytes
  output logic [dgcp_pkg::NCH-1:0] ch_ready, // byte may move
  output logic [dgcp_pkg::NCH-1:0] ch_done // end of transfer on match
);
  // ***********************************************************
  // state
  // ***********************************************************
  logic on; // module enable
  logic suspend; // transfer hold-off
  logic busy; // dma_active_flag
  logic [dgcp_pkg::NCH-1:0] mode; // pattern terminate mode per channel
  logic [dgcp_pkg::NCH-1:0] hit; // sticky match flags
  logic [dgcp_pkg::BYTE_W-1:0] pattern [dgcp_pkg::NCH]; // match bytes

  // ***********************************************************
  // channel gating
  // ***********************************************************
  // transfers move only when enabled and not suspended
  wire logic run = on & ~suspend;
  wire logic [dgcp_pkg::NCH-1:0] xfer;
  wire logic next_busy = on | (|xfer);

  // ***********************************************************
  // write decode
  // ***********************************************************
  // address and data are taken together, one write at a time
  wire logic wr_take = awvalid & wvalid & ~bvalid & ce;
  wire logic [dgcp_pkg::IDX_W-1:0] aw_idx =
    awaddr[dgcp_pkg::IDX_LSB +: dgcp_pkg::IDX_W];
  // upper address bits must be clear too, so the map has no aliases
  wire logic aw_aligned = (awaddr[dgcp_pkg::IDX_LSB-1:0] == 2'h0)
    & (awaddr[dgcp_pkg::ADDR_W-1:dgcp_pkg::IDX_LSB+dgcp_pkg::IDX_W] == 2'h0);
  wire logic wr_glob = wr_take & aw_aligned & (aw_idx == dgcp_pkg::IDX_GLOBAL);
  wire logic wr_mode = wr_take & aw_aligned & (aw_idx == dgcp_pkg::IDX_MODE);
  wire logic wr_hit = wr_take & aw_aligned & (aw_idx == dgcp_pkg::IDX_HIT);
  wire logic wr_ctl_lane = wstrb[dgcp_pkg::LANE_CTRL];
  wire logic wr_low_lane = wstrb[dgcp_pkg::LANE_MATCH];
  wire logic [dgcp_pkg::NCH-1:0] wr_match;
  wire logic aw_match_hit = |wr_match;
  wire logic aw_ok = aw_aligned & ((aw_idx == dgcp_pkg::IDX_GLOBAL)
    | (aw_idx == dgcp_pkg::IDX_MODE) | (aw_idx == dgcp_pkg::IDX_HIT)
    | aw_match_hit);
  // set wins over a write-one clear
  wire logic [dgcp_pkg::NCH-1:0] hit_clr =
    (wr_hit & wr_low_lane) ? wdata[dgcp_pkg::NCH-1:0] : dgcp_pkg::RST_CH;
  wire logic [dgcp_pkg::NCH-1:0] next_hit = (hit & ~hit_clr) | ch_done;

  assign awready = wr_take;
  assign wready = wr_take;

  // ***********************************************************
  // read decode
  // ***********************************************************
  wire logic rd_take = arvalid & ~rvalid & ce;
  wire logic [dgcp_pkg::IDX_W-1:0] ar_idx =
    araddr[dgcp_pkg::IDX_LSB +: dgcp_pkg::IDX_W];
  wire logic ar_aligned = (araddr[dgcp_pkg::IDX_LSB-1:0] == 2'h0)
    & (araddr[dgcp_pkg::ADDR_W-1:dgcp_pkg::IDX_LSB+dgcp_pkg::IDX_W] == 2'h0);
  wire logic [dgcp_pkg::DATA_W-1:0] rd_match [dgcp_pkg::NCH];
  wire logic [dgcp_pkg::NCH-1:0] ar_match;
  // only the three documented bits are live, the rest read zero
  wire logic [dgcp_pkg::DATA_W-1:0] rd_glob = dgcp_pkg::ZERO_WORD
    | (dgcp_pkg::DATA_W'(on) << dgcp_pkg::ON_BIT)
    | (dgcp_pkg::DATA_W'(suspend) << dgcp_pkg::SUSPEND_BIT)
    | (dgcp_pkg::DATA_W'(busy) << dgcp_pkg::BUSY_BIT);
  wire logic [dgcp_pkg::DATA_W-1:0] rd_mode = dgcp_pkg::DATA_W'(mode);
  wire logic [dgcp_pkg::DATA_W-1:0] rd_hit = dgcp_pkg::DATA_W'(hit);
  logic [dgcp_pkg::DATA_W-1:0] rd_chan; // or of selected match words
  wire logic ar_ok = ar_aligned & ((ar_idx == dgcp_pkg::IDX_GLOBAL)
    | (ar_idx == dgcp_pkg::IDX_MODE) | (ar_idx == dgcp_pkg::IDX_HIT)
    | (|ar_match));
  wire logic [dgcp_pkg::DATA_W-1:0] rd_word =
    !ar_aligned ? dgcp_pkg::ZERO_WORD :
    (ar_idx == dgcp_pkg::IDX_GLOBAL) ? rd_glob :
    (ar_idx == dgcp_pkg::IDX_MODE) ? rd_mode :
    (ar_idx == dgcp_pkg::IDX_HIT) ? rd_hit : rd_chan;

  assign arready = rd_take;

  // ***********************************************************
  // per-channel logic
  // ***********************************************************
  genvar gi;
  generate
    for (gi = 0; gi < dgcp_pkg::NCH; gi = gi + 1) begin : g_ch
      assign ch_ready[gi] = run;
      assign xfer[gi] = ch_beat[gi].valid & run;
      assign wr_match[gi] = wr_take & aw_aligned
        & (aw_idx == dgcp_pkg::IDX_MATCH0 + dgcp_pkg::IDX_W'(gi));
      assign ar_match[gi] =
        (ar_idx == dgcp_pkg::IDX_MATCH0 + dgcp_pkg::IDX_W'(gi));
      // upper bits of the match word read zero
      assign rd_match[gi] = dgcp_pkg::DATA_W'(pattern[gi]);

      // match byte store, low byte lane only
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pattern[gi] <= dgcp_pkg::RST_BYTE;
        end else if (wr_match[gi] && wr_low_lane) begin
          pattern[gi] <= wdata[dgcp_pkg::BYTE_W-1:0];
        end
      end

      dgcp_match_unit u_match (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .xfer(xfer[gi]),
        .data(ch_beat[gi].data),
        .pattern(pattern[gi]),
        .pattern_mode(mode[gi]),
        .done(ch_done[gi])
      );
    end
  endgenerate

  // match word selection for reads
  always_comb begin
    rd_chan = dgcp_pkg::ZERO_WORD;
    for (int i = 0; i < dgcp_pkg::NCH; i++) begin
      if (ar_match[i]) begin
        rd_chan = rd_chan | rd_match[i];
      end
    end
  end

  // ***********************************************************
  // control registers
  // ***********************************************************
  // enable, suspend, modes and hit flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on <= dgcp_pkg::RST_BIT;
      suspend <= dgcp_pkg::RST_BIT;
      mode <= dgcp_pkg::RST_CH;
      hit <= dgcp_pkg::RST_CH;
    end else if (ce) begin
      if (wr_glob && wr_ctl_lane) begin
        on <= wdata[dgcp_pkg::ON_BIT];
        suspend <= wdata[dgcp_pkg::SUSPEND_BIT];
      end
      if (wr_mode && wr_low_lane) begin
        mode <= wdata[dgcp_pkg::NCH-1:0];
      end
      hit <= next_hit;
    end
  end

  // busy follows enable and any moving byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= dgcp_pkg::RST_BIT;
    end else if (ce) begin
      busy <= next_busy;
    end
  end

  // ***********************************************************
  // bus responses
  // ***********************************************************
  // write response, held until bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= dgcp_pkg::RST_BIT;
      bresp <= dgcp_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_take) begin
        bvalid <= 1'b1;
        bresp <= aw_ok ? dgcp_pkg::RESP_OKAY : dgcp_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read response, held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= dgcp_pkg::RST_BIT;
      rdata <= dgcp_pkg::ZERO_WORD;
      rresp <= dgcp_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_take) begin
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= ar_ok ? dgcp_pkg::RESP_OKAY : dgcp_pkg::RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  off_blocks_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !on |-> (ch_ready == dgcp_pkg::RST_CH))
    else $error("channel ready while module disabled");

  on_runs_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && wr_glob && wr_ctl_lane && wdata[dgcp_pkg::ON_BIT]
      && !wdata[dgcp_pkg::SUSPEND_BIT]) |=> (&ch_ready))
    else $error("enable write did not open the channels");

  suspend_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    suspend |-> (xfer == dgcp_pkg::RST_CH))
    else $error("byte moved while suspended");

  busy_set_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && on) |=> busy)
    else $error("busy low while module active");

  busy_clear_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && !on && xfer == dgcp_pkg::RST_CH) |=> !busy)
    else $error("busy high while idle and disabled");

  ctrl_zero_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (rd_take && ar_aligned && ar_idx == dgcp_pkg::IDX_GLOBAL)
      |=> (rdata[31:16] == 16'h0000 && rdata[14:13] == 2'h0
        && rdata[10:0] == 11'h000
        && rdata[dgcp_pkg::ON_BIT] == $past(on)))
    else $error("control readback wrong");

  match_zero_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (rd_take && (|ar_match) && ar_aligned)
      |=> (rdata[31:8] == 24'h000000))
    else $error("match word upper bits not zero");

  hit_sticky_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && (|ch_done)) |=> ((hit & $past(ch_done)) == $past(ch_done)))
    else $error("match flag lost");
endmodule

// ### verification/dgcp_tb.sv
// testbench: register access and pattern match checks of the dma block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb;
  // ***********************************************************
  // clock, reset and design hookup
  // ***********************************************************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  dgcp_pkg::dgcp_beat_t [dgcp_pkg::NCH-1:0] ch_beat = '0;
  logic [3:0] ch_ready, ch_done;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  logic [1:0] resp;
  logic [31:0] rd;
  logic [3:0] d1, d2;
  // clock at 40 MHz
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  dgcp_top dgcp_top_inst (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .ch_beat(ch_beat), .ch_ready(ch_ready), .ch_done(ch_done)
  );
  // ***********************************************************
  // closing report and hang guard
  // ***********************************************************
  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // cut the run short if a handshake never completes
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      tally_and_finish();
    end
  end
  // ***********************************************************
  // bus and channel tasks
  // ***********************************************************
  function automatic logic [7:0] addr_of(input logic [3:0] i);
    addr_of = {2'h0, i, 2'h0};
  endfunction
  // axi4-lite write, address and data offered together
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  // axi4-lite read, rready held until rvalid is seen
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // offer one byte on the chosen channels, capture the done pulse and after
  task automatic send(input logic [3:0] en, input logic [7:0] d,
                      output logic [3:0] first, output logic [3:0] next);
    @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      ch_beat[i].valid <= en[i];
      ch_beat[i].data <= d;
    end
    @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      ch_beat[i].valid <= 1'b0;
    end
    #1 first = ch_done;
    @(posedge aclk);
    #1 next = ch_done;
  endtask
  // ***********************************************************
  // test sequence
  // ***********************************************************
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // reset state: module off, idle, pattern cleared
    axi_read(addr_of(dgcp_pkg::IDX_GLOBAL), rd, resp);
    `CHK(rd, 32'h0000_0000)
    `CHK(resp, dgcp_pkg::RESP_OKAY)
    `CHK(ch_ready, 4'h0)
    axi_read(addr_of(dgcp_pkg::IDX_MATCH0), rd, resp);
    `CHK(rd, 32'h0000_0000)
    // all ones: only on, suspend and busy survive
    axi_write(addr_of(dgcp_pkg::IDX_GLOBAL), 32'hffff_ffff, resp);
    `CHK(resp, dgcp_pkg::RESP_OKAY)
    axi_read(addr_of(dgcp_pkg::IDX_GLOBAL), rd, resp);
    `CHK(rd, 32'h0000_9800)
    #1 `CHK(ch_ready, 4'h0)
    // on without suspend: transfers may run, busy reads one
    axi_write(addr_of(dgcp_pkg::IDX_GLOBAL), 32'h0000_8000, resp);
    #1 `CHK(ch_ready, 4'hf)
    axi_read(addr_of(dgcp_pkg::IDX_GLOBAL), rd, resp);
    `CHK(rd, 32'h0000_8800)
    // match bytes: upper bits dropped on every channel
    for (int n = 0; n < 4; n++) begin
      axi_write(addr_of(dgcp_pkg::IDX_MATCH0 + 4'(n)),
                32'hffff_ffa5 ^ {8'(n), 24'h0}, resp);
      axi_read(addr_of(dgcp_pkg::IDX_MATCH0 + 4'(n)), rd, resp);
      `CHK(rd, 32'h0000_00a5)
    end
    // pattern mode on channel 0 only, same byte on all channels
    axi_write(addr_of(dgcp_pkg::IDX_MODE), 32'h0000_0001, resp);
    send(4'hf, 8'ha5, d1, d2);
    `CHK(d1, 4'h1)
    `CHK(d2, 4'h0)
    send(4'h1, 8'ha4, d1, d2);
    `CHK(d1, 4'h0)
    axi_read(addr_of(dgcp_pkg::IDX_HIT), rd, resp);
    `CHK(rd, 32'h0000_0001)
    axi_write(addr_of(dgcp_pkg::IDX_HIT), 32'h0000_0001, resp);
    axi_read(addr_of(dgcp_pkg::IDX_HIT), rd, resp);
    `CHK(rd, 32'h0000_0000)
    // suspended: a matching byte does not move
    axi_write(addr_of(dgcp_pkg::IDX_GLOBAL), 32'h0000_9000, resp);
    send(4'h1, 8'ha5, d1, d2);
    `CHK(d1, 4'h0)
    // disable, then leave a quiet cycle before the next access
    axi_write(addr_of(dgcp_pkg::IDX_GLOBAL), 32'h0000_0000, resp);
    @(posedge aclk);
    #1 `CHK(ch_ready, 4'h0)
    send(4'h1, 8'ha5, d1, d2);
    `CHK(d1, 4'h0)
    axi_read(addr_of(dgcp_pkg::IDX_GLOBAL), rd, resp);
    `CHK(rd, 32'h0000_0000)
    // an alias of the control word above the map is refused, no effect
    axi_write(8'h40, 32'h0000_8000, resp);
    `CHK(resp, dgcp_pkg::RESP_SLVERR)
    `CHK(ch_ready, 4'h0)
    // unmapped word is refused both ways
    axi_write(8'h0c, 32'h0000_00ff, resp);
    `CHK(resp, dgcp_pkg::RESP_SLVERR)
    axi_read(8'h0c, rd, resp);
    `CHK(resp, dgcp_pkg::RESP_SLVERR)
    `CHK(rd, 32'h0000_0000)
    tally_and_finish();
  end
endmodule
